// ### logic/hwsl_defines.vh
// register map, field positions, reset values and timing constants
`ifndef HWSL_DEFINES_VH
`define HWSL_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define HWSL_ADDR_CONTROL 8'h00
`define HWSL_ADDR_REF_STATUS 8'h04
`define HWSL_ADDR_PORT_DATA 8'h08
`define HWSL_ADDR_PIN_SELECT 8'h0C
`define HWSL_ADDR_PORT_DIR 8'h10
`define HWSL_ADDR_IRQ_STATUS 8'h14
`define HWSL_ADDR_IRQ_MASK 8'h18

// ----------------------------------------
// control fields
// ----------------------------------------
`define HWSL_CTL_FLAG 7
`define HWSL_CTL_LEVEL 6
`define HWSL_CTL_DELAY 5
`define HWSL_CTL_SRC_HI 4
`define HWSL_CTL_SRC_LO 2
`define HWSL_CTL_SHORT 1
`define HWSL_CTL_DIV16 0
`define HWSL_CTL_RESET 8'h20

// ----------------------------------------
// source selection codes
// ----------------------------------------
`define HWSL_SRC_NONE 3'h0
`define HWSL_SRC_PIN1 3'h2
`define HWSL_SRC_PIN2 3'h3
`define HWSL_SRC_PIN3 3'h4
`define HWSL_SRC_LOW_AND 3'h5
`define HWSL_SRC_HIGH_AND 3'h6
`define HWSL_SRC_ALL_AND 3'h7

// ----------------------------------------
// reference status codes
// ----------------------------------------
`define HWSL_REF_NONE 2'h0
`define HWSL_REF_READ 2'h1
`define HWSL_REF_WRITE 2'h2

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define HWSL_IRQ_WAKE 0
`define HWSL_IRQ_RESTART 1
`define HWSL_IRQ_LATCH 2

// ----------------------------------------
// timing
// ----------------------------------------
`define HWSL_CLOCK_KHZ 10000
`define HWSL_RESET_TIME_US 2500
`define HWSL_PRESCALE 16

`endif

// ### logic/hwsl_wake.v
// halt wake source logic with its register slave
//
// Overview of operation
// R1: read-only flag bit 7 shows last startup: 0 power-on, 1 wake recovery
// R2: bit 6 picks low or high level as the combinational wake level
// R3: bit 5 switches the restart delay; keep it 1 with a crystal
// R4: bit1=0, bit5=0: wake reset period equals the power-on period
// R5: bit1=1, bit5=0: period ends on crystal ready, at least 2.5 ms from power-up
// R6: bit 0 enables divide-by-16 prescaler on the system and timer clock; here only timer_clock_tick is divided
// R7: prescaler enable cleared on power-on reset and on wake recovery
// R8: pin select bit n makes port b pin n a change wake source; resets 0
// R9: software sets a pin as input before selecting it
// R10: with no reference latched, a selected pin wakes while it reads zero
// R11: reads or writes of port b data latch the reference for selected pins
// R12: a selected pin wakes while it differs from its latched reference
// R13: reference status shows 01 after a port read, 10 after a port write
// R14: writing 00 to reference status returns to wake-on-zero behaviour
// R15: chosen combinational source equal to level bit raises a wake event
// R16: source field 000 selects no wake source
// R17: combinational sources ignore output pins and change-selected pins
// R18: any active source, combinational or change detect, raises a wake event
// R19: reserved source codes behave like no source
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "hwsl_defines.vh"

module hwsl_wake #(
   parameter RESET_CYCLES = (`HWSL_RESET_TIME_US * `HWSL_CLOCK_KHZ + 999) / 1000
)(
   input wire clock,
   input wire rst_b,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg [31:0] hrdata,
   output reg hresp,
   input wire [7:0] port_b_pin,
   output reg [7:0] port_b_out,
   output reg [7:0] port_b_oe,
   input wire [2:0] port_c_pin,
   input wire crystal_ok,
   input wire halt_req,
   output reg halted,
   output reg core_reset_b,
   output reg wake_event,
   output reg timer_clock_tick,
   output reg irq
);

   localparam ST_RUN = 3'b001;
   localparam ST_HALT = 3'b010;
   localparam ST_RESTART = 3'b100;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   reg [7:0] pb_meta;
   reg [7:0] pb_sync;
   reg [2:0] pc_meta;
   reg [2:0] pc_sync;
   reg xt_meta;
   reg xt_sync;

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pb_meta <= 8'h00;
         pb_sync <= 8'h00;
         pc_meta <= 3'h0;
         pc_sync <= 3'h0;
         xt_meta <= 1'b0;
         xt_sync <= 1'b0;
      end
      else
      begin
         pb_meta <= port_b_pin;
         pb_sync <= pb_meta;
         pc_meta <= port_c_pin;
         pc_sync <= pc_meta;
         xt_meta <= crystal_ok;
         xt_sync <= xt_meta;
      end
   end

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   reg [7:0] control;
   reg [1:0] ref_status;
   reg [7:0] ref_value;
   reg [7:0] pin_select;
   reg [2:0] irq_status;
   reg [2:0] irq_mask;
   reg [2:0] state;
   reg wr_pend;
   reg [7:0] wr_addr;
   reg [31:0] next_rdata;
   reg [2:0] next_irq_status;
   reg [2:0] next_state;
   wire addr_take;
   wire rd_take;
   wire [7:0] pin_input;
   wire [7:0] port_read_value;
   wire port_read;
   wire port_write;
   wire wr_data;

   assign addr_take = hsel & hready & htrans[1];
   assign rd_take = addr_take & ~hwrite;
   assign wr_data = wr_pend;
   assign pin_input = ~port_b_oe;
   assign port_read_value = (pb_sync & pin_input) | (port_b_out & port_b_oe);
   assign port_read = rd_take && (haddr[7:0] == `HWSL_ADDR_PORT_DATA) && (haddr[31:8] == 24'h0);
   assign port_write = wr_data && (wr_addr == `HWSL_ADDR_PORT_DATA);

   always @*
   begin
      next_rdata = 32'h00000000;
      if (haddr[31:8] != 24'h0)
         next_rdata = 32'h00000000;
      else if (haddr[7:0] == `HWSL_ADDR_CONTROL)
         next_rdata = {24'h0, control};
      else if (haddr[7:0] == `HWSL_ADDR_REF_STATUS)
         next_rdata = {30'h0, ref_status};
      else if (haddr[7:0] == `HWSL_ADDR_PORT_DATA)
         next_rdata = {24'h0, port_read_value};
      else if (haddr[7:0] == `HWSL_ADDR_PORT_DIR)
         next_rdata = {24'h0, ~port_b_oe};
      else if (haddr[7:0] == `HWSL_ADDR_IRQ_STATUS)
         next_rdata = {29'h0, irq_status};
      else if (haddr[7:0] == `HWSL_ADDR_IRQ_MASK)
         next_rdata = {29'h0, irq_mask};
      else
         next_rdata = 32'h00000000;
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= addr_take & hwrite & (haddr[31:8] == 24'h0);
         if (addr_take)
            wr_addr <= haddr[7:0];
         if (rd_take)
            hrdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // wake sources
   // ----------------------------------------
   wire [7:0] change_hit;
   wire [7:0] comb_pin;
   wire level;
   reg comb_out;
   reg comb_valid;
   wire comb_hit;
   wire wake_any;

   genvar n;
   generate
      for (n = 0; n < 8; n = n + 1)
      begin : g_pin
         // change detect per pin
         assign change_hit[n] = pin_select[n] & pin_input[n] &
            ((ref_status == `HWSL_REF_NONE) ? ~pb_sync[n] : (pb_sync[n] ^ ref_value[n])); // R10 R12 R14
         // ignored pins sit at the neutral level of the and terms
         assign comb_pin[n] = pb_sync[n] | ~pin_input[n] | pin_select[n]; // R17
      end
   endgenerate

   assign level = control[`HWSL_CTL_LEVEL];

   always @*
   begin
      comb_out = 1'b0;
      comb_valid = 1'b1;
      case (control[`HWSL_CTL_SRC_HI:`HWSL_CTL_SRC_LO])
         `HWSL_SRC_PIN1: comb_out = pc_sync[0];
         `HWSL_SRC_PIN2: comb_out = pc_sync[1];
         `HWSL_SRC_PIN3: comb_out = pc_sync[2];
         `HWSL_SRC_LOW_AND: comb_out = &comb_pin[3:0];
         `HWSL_SRC_HIGH_AND: comb_out = &comb_pin[7:4];
         `HWSL_SRC_ALL_AND: comb_out = &comb_pin;
         default: comb_valid = 1'b0; // R16 R19
      endcase
   end

   assign comb_hit = comb_valid & (comb_out == level); // R2 R15
   assign wake_any = comb_hit | (|change_hit); // R18

   // ----------------------------------------
   // halt and restart sequencing
   // ----------------------------------------
   reg [15:0] restart_count;
   reg [15:0] powerup_count;
   reg restart_done;
   wire powerup_met;

   assign powerup_met = (powerup_count >= RESET_CYCLES[15:0]);

   always @*
   begin
      restart_done = 1'b0;
      if (control[`HWSL_CTL_DELAY])
         restart_done = xt_sync && (restart_count >= RESET_CYCLES[15:0] - 16'h0001); // R3
      else if (control[`HWSL_CTL_SHORT])
         restart_done = xt_sync && powerup_met; // R5
      else
         restart_done = (restart_count >= RESET_CYCLES[15:0] - 16'h0001); // R4
   end

   always @*
   begin
      next_state = state;
      case (state)
         ST_RUN: if (halt_req) next_state = ST_HALT;
         ST_HALT: if (wake_any) next_state = ST_RESTART;
         ST_RESTART: if (restart_done) next_state = ST_RUN;
         default: next_state = ST_RUN;
      endcase
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= ST_RUN;
         restart_count <= 16'h0000;
         powerup_count <= 16'h0000;
         halted <= 1'b0;
         core_reset_b <= 1'b1;
         wake_event <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (!powerup_met)
            powerup_count <= powerup_count + 16'h0001;
         if (state == ST_RESTART && !(control[`HWSL_CTL_DELAY] && !xt_sync))
            restart_count <= restart_count + 16'h0001;
         else if (state != ST_RESTART)
            restart_count <= 16'h0000;
         halted <= next_state[1];
         core_reset_b <= ~next_state[2];
         wake_event <= wake_any;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   wire recover;
   wire [1:0] latch_kind;
   wire latch_now;

   assign recover = (state == ST_HALT) && wake_any;
   assign latch_now = (port_read | port_write) & (|pin_select);
   assign latch_kind = port_write ? `HWSL_REF_WRITE : `HWSL_REF_READ;

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         control <= `HWSL_CTL_RESET;
         ref_status <= `HWSL_REF_NONE;
         ref_value <= 8'h00;
         pin_select <= 8'h00; // R8
         port_b_out <= 8'h00;
         port_b_oe <= 8'h00;
         irq_mask <= 3'h0;
      end
      else
      begin
         if (wr_data && wr_addr == `HWSL_ADDR_CONTROL)
            control[6:0] <= hwdata[6:0]; // R6
         if (recover)
         begin
            control[`HWSL_CTL_FLAG] <= 1'b1; // R1
            control[`HWSL_CTL_DIV16] <= 1'b0; // R7
         end
         if (wr_data && wr_addr == `HWSL_ADDR_PIN_SELECT)
            pin_select <= hwdata[7:0]; // R8
         if (port_write)
            port_b_out <= hwdata[7:0];
         if (wr_data && wr_addr == `HWSL_ADDR_PORT_DIR)
            port_b_oe <= ~hwdata[7:0];
         if (wr_data && wr_addr == `HWSL_ADDR_IRQ_MASK)
            irq_mask <= hwdata[2:0];
         if (latch_now)
         begin
            ref_value <= port_write ? hwdata[7:0] : port_read_value; // R11
            ref_status <= latch_kind; // R13
         end
         else if (wr_data && wr_addr == `HWSL_ADDR_REF_STATUS && hwdata[1:0] == `HWSL_REF_NONE)
            ref_status <= `HWSL_REF_NONE; // R14
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   always @*
   begin
      next_irq_status = irq_status;
      if (wr_data && wr_addr == `HWSL_ADDR_IRQ_STATUS)
         next_irq_status = irq_status & ~hwdata[2:0];
      if (wake_any && !wake_event)
         next_irq_status[`HWSL_IRQ_WAKE] = 1'b1;
      if (state == ST_RESTART && restart_done)
         next_irq_status[`HWSL_IRQ_RESTART] = 1'b1;
      if (latch_now)
         next_irq_status[`HWSL_IRQ_LATCH] = 1'b1;
   end

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         irq_status <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_mask);
      end
   end

   // ----------------------------------------
   // clock prescaler
   // ----------------------------------------
   reg [3:0] prescale_count;

   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prescale_count <= 4'h0;
         timer_clock_tick <= 1'b0;
      end
      else
      begin
         prescale_count <= prescale_count + 4'h1;
         if (control[`HWSL_CTL_DIV16])
            timer_clock_tick <= (prescale_count == 4'hF); // R6
         else
            timer_clock_tick <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// ### sim/hwsl_pins.sv
// port pin and crystal model for the wake bench
`timescale 1ns/1ps
`default_nettype none
module hwsl_pins (
   input wire clock,
   input wire [7:0] drive_b,
   input wire [7:0] port_b_out,
   input wire [7:0] port_b_oe,
   input wire [2:0] drive_c,
   input wire xtal_on,
   output logic [7:0] port_b_pin,
   output logic [2:0] port_c_pin,
   output logic crystal_ok
);
   integer n = 0;
   // pin level: module drives where enabled, outside elsewhere
   assign port_b_pin = (port_b_out & port_b_oe) | (drive_b & ~port_b_oe);
   assign port_c_pin = drive_c;
   // oscillation needs some cycles to reach a good swing
   always @(posedge clock)
   begin
      if (!xtal_on)
         n = 0;
      else if (n < 12)
         n = n + 1;
      crystal_ok <= xtal_on && n >= 12;
   end
endmodule
`default_nettype wire

// ### sim/hwsl_props.sv
// assertion checker for the halt wake logic
`timescale 1ns/1ps
`default_nettype none
module hwsl_props (
   input wire clock,
   input wire rst_b,
   input wire hreadyout,
   input wire hresp,
   input wire halt_req,
   input wire halted,
   input wire core_reset_b,
   input wire wake_event,
   input wire timer_clock_tick
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // bus response, halt, restart and timer tick checks
   // ----------------------------------------
   sequence s_halt;
      halt_req && !halted && core_reset_b;
   endsequence
   sequence s_leave;
      halted ##1 !halted;
   endsequence
   a_ready_high: assert property (hreadyout)
      else $error("ready low");
   a_resp_okay: assert property (!hresp)
      else $error("error response");
   a_halt_enter: assert property (s_halt |=> halted)
      else $error("halt not taken");
   a_halt_hold: assert property (halted |=> halted || wake_event)
      else $error("left halt without wake");
   a_wake_restart: assert property (s_leave |-> !core_reset_b)
      else $error("no restart after halt");
   a_restart_run: assert property (!core_reset_b |-> !halted)
      else $error("halted during restart");
   a_restart_min: assert property ($fell(core_reset_b) |-> (!core_reset_b)[*2])
      else $error("restart too short");
   a_tick_after: assert property ($rose(core_reset_b) |-> timer_clock_tick[*4])
      else $error("prescaler left on");
   a_tick_pulse: assert property ($fell(timer_clock_tick) |-> ##[1:16] timer_clock_tick)
      else $error("tick gap too long");
endmodule
bind hwsl_wake hwsl_props hwsl_props_i (.clock(clock), .rst_b(rst_b),
   .hreadyout(hreadyout), .hresp(hresp), .halt_req(halt_req), .halted(halted),
   .core_reset_b(core_reset_b), .wake_event(wake_event),
   .timer_clock_tick(timer_clock_tick));
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the halt wake logic
`timescale 1ns/1ps
`default_nettype none
`include "hwsl_defines.vh"
module tb_top;
   localparam A_CT = `HWSL_ADDR_CONTROL;
   localparam A_RF = `HWSL_ADDR_REF_STATUS;
   localparam A_PD = `HWSL_ADDR_PORT_DATA;
   localparam A_SL = `HWSL_ADDR_PIN_SELECT;
   localparam A_DR = `HWSL_ADDR_PORT_DIR;
   localparam A_IS = `HWSL_ADDR_IRQ_STATUS;
   localparam A_IM = `HWSL_ADDR_IRQ_MASK;
   logic clock = 0;
   logic rst_b = 0;
   logic [31:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic hwrite = 0;
   logic [31:0] hwdata = 0;
   logic halt_req = 0;
   logic xtal_on = 1;
   logic [7:0] drive_b = 0;
   logic [2:0] drive_c = 0;
   wire hreadyout, hresp, halted, core_reset_b, wake_event, tick, irq, xok;
   wire [31:0] hrdata;
   wire [7:0] pb_pin, pb_out, pb_oe;
   wire [2:0] pc_pin;
   integer num_errors = 0, cmp_count = 0, seed = 46190;
   integer ctl = 8'h20, sel = 0, dir = 8'hFF, rf = 0, rs = 0, outv = 0;
   integer r, i, k, pb, pc;
   hwsl_wake #(.RESET_CYCLES(20)) hwsl_wake_i (.clock(clock), .rst_b(rst_b),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .port_b_pin(pb_pin), .port_b_out(pb_out), .port_b_oe(pb_oe),
      .port_c_pin(pc_pin), .crystal_ok(xok), .halt_req(halt_req), .halted(halted),
      .core_reset_b(core_reset_b), .wake_event(wake_event),
      .timer_clock_tick(tick), .irq(irq));
   hwsl_pins hwsl_pins_i (.clock(clock), .drive_b(drive_b), .port_b_out(pb_out),
      .port_b_oe(pb_oe), .drive_c(drive_c), .xtal_on(xtal_on), .port_b_pin(pb_pin),
      .port_c_pin(pc_pin), .crystal_ok(xok));
   initial
      forever #50 clock = ~clock;
   // ----------------------------------------
   // reference model and bus tasks
   // ----------------------------------------
   function integer exp_wake(input integer b, input integer c);
      integer s, v, m;
      begin
         m = b | sel | (dir ^ 255);
         s = ctl >> 2 & 7;
         v = s == 2 ? c & 1 : s == 3 ? c >> 1 & 1 : s == 4 ? c >> 2 & 1 :
            s == 5 ? (m & 15) == 15 : s == 6 ? (m & 240) == 240 : s == 7 ? (m & 255) == 255 : 2;
         exp_wake = v == (ctl >> 6 & 1) || (sel & dir & (rs == 0 ? ~b : b ^ rf) & 255) != 0;
      end
   endfunction
   task wrap_up;
      begin
         if (num_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
         end
      end
   endtask
   task rdy;
      begin
         k = 0;
         @(posedge clock);
         while (hreadyout !== 1'b1)
         begin
            k = k + 1;
            if (k > 50)
            begin
               num_errors = num_errors + 1;
               wrap_up;
            end
            @(posedge clock);
         end
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         haddr <= {24'h000000, a};
         hwrite <= w;
         htrans <= 2'h2;
         rdy;
         htrans <= 2'h0;
         hwdata <= d;
         rdy;
         r = hrdata;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         bus(0, a, 0);
         chk(r, e);
      end
   endtask
   task wt(input integer n);
      repeat (n) @(posedge clock);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge clock);
      rst_b <= 1;
      @(posedge clock);
      rd(A_CT, 32'h20);
      rd(A_RF, 32'h0);
      rd(A_SL, 32'h0);
      rd(A_DR, 32'hFF);
      rd(8'hFC, 32'h0);
      bus(1, A_CT, 32'hFF);
      rd(A_CT, 32'h7F);
      pb = 0;
      for (i = 0; i < 32; i = i + 1)
      begin
         @(posedge clock);
         pb = pb + tick;
      end
      chk(pb, 2);
      for (i = 0; i < 48; i = i + 1)
      begin
         pb = $random(seed) & 255;
         pc = $random(seed) & 7;
         dir = $random(seed) & 255;
         sel = $random(seed) & dir;
         ctl = 8'h20 | (i & 7) << 2 | (i & 8) << 3;
         drive_b <= pb;
         drive_c <= pc;
         bus(1, A_DR, dir);
         bus(1, A_SL, sel);
         bus(1, A_CT, ctl);
         if (i % 3 == 0)
         begin
            bus(1, A_RF, 0);
            rs = 0;
         end
         else if (i % 3 == 1)
         begin
            outv = $random(seed) & 255;
            bus(1, A_PD, outv);
            rf = sel != 0 ? outv : rf;
            rs = sel != 0 ? 2 : rs;
         end
         else
         begin
            rd(A_PD, (pb & dir | outv & ~dir) & 255);
            rf = sel != 0 ? r : rf;
            rs = sel != 0 ? 1 : rs;
         end
         rd(A_RF, rs);
         wt(6);
         chk(wake_event, exp_wake(pb, pc));
      end
      sel = 0;
      bus(1, A_SL, 0);
      bus(1, A_CT, 8'h20);
      drive_c <= 0;
      wt(6);
      bus(1, A_IS, 7);
      bus(1, A_IM, 1);
      wt(2);
      chk(irq, 1'b0);
      bus(1, A_CT, 8'h69);
      drive_c <= 1;
      wt(6);
      chk(irq, 1'b1);
      bus(1, A_IM, 0);
      wt(2);
      chk(irq, 1'b0);
      bus(1, A_IM, 1);
      wt(2);
      chk(irq, 1'b1);
      bus(1, A_IS, 1);
      wt(2);
      chk(irq, 1'b0);
      drive_c <= 0;
      wt(6);
      halt_req <= 1;
      @(posedge clock);
      halt_req <= 0;
      wt(2);
      chk(halted, 1'b1);
      drive_c <= 1;
      for (i = 0; i < 300 && core_reset_b !== 1'b0; i = i + 1)
         @(posedge clock);
      chk(core_reset_b, 1'b0);
      for (i = 0; i < 300 && core_reset_b !== 1'b1; i = i + 1)
         @(posedge clock);
      chk(core_reset_b, 1'b1);
      chk(i, 20);
      rd(A_CT, 32'hE8);
      rd(A_IS, 32'h3);
      chk(irq, 1'b1);
      wt(4);
      wrap_up;
   end
endmodule
`default_nettype wire
